// *** verilog/trng_health_monitor.v ***
// Health tests, output selection and alarm path for a PLL-jitter and a delay-chain generator.
// Assumes pins from both entropy cores are asynchronous; the post-processor takes bit/valid.
`timescale 1ns/1ps
`include "trng_health_map.vh"

// Summary of operation
// [RL1] Evaluation: XOR or raw bit, raw default
// [RL2] User mode: raw stream only to post-processor
// [RL3] Count samples over 255 pattern periods
// [RL4] Empty period raises total failure and interrupt
// [RL5] Sample count per pattern period is parameter one
// [RL6] Jitter variance over 4080 pattern periods
// [RL7] Strict threshold checks on both parameters
// [RL8] 40-tap chain captured into 40-bit register
// [RL9] Sampling tick divided from reference clock
// [RL10] Edge position difference gives one raw bit
// [RL11] Parity filter XORs pairs of raw bits
// [RL12] Evaluation exposes chain raw and parity bits
// [RL13] Oscillator toggle checked every two cycles
// [RL14] Alarm when sample holds no edge
// [RL15] Count 111 per 512 bits, bounds 35..93
// [RL16] Count transitions per 512 bits, bounds 185..326
// [RL17] Repetition and proportion tests before post-processing
// [RL18] Continuous test window is 4096 pattern periods
// [RL19] All results gathered in 64-bit state word
// [RL20] Any error raises alarm and interrupt
// [RL21] Alarm halts streams until generator reset
// [RL22] Startup window must pass before data flows; only the post-processor streams wait for it, evaluation outputs do not
// [RL23] Error bits stay set until reset
module trng_health_monitor #(
	parameter SAMPLE_DIV = 16,
	parameter RCT_CUTOFF = 32
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Control
	input wire eval_mode,
	input wire output_select,
	input wire [15:0] period_ratio,
	// Entropy core pins
	input wire xor_out,
	input wire pll_raw,
	input wire ring_osc_out,
	input wire [`CHAIN_LEN-1:0] chain_taps,
	// Post-processor streams
	output reg pll_pp_bit,
	output reg pll_pp_valid,
	output reg dc_pp_bit,
	output reg dc_pp_valid,
	// Evaluation outputs
	output reg eval_pll_bit,
	output reg eval_pll_valid,
	output reg eval_dc_raw,
	output reg eval_dc_parity,
	output reg eval_dc_valid,
	// Status
	output reg [63:0] state_word,
	output reg [15:0] sample_count_param,
	output reg [15:0] jitter_variance_param,
	output reg total_failure_alarm,
	output reg alarm,
	output reg irq_req,
	output reg ready
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Index of first neighbour pair that differs, zero when none
	function [5:0] first_edge;
		input [`CHAIN_LEN-1:0] s;
		integer i;
		begin
			first_edge = 6'h00;
			for (i = `CHAIN_LEN - 2; i >= 0; i = i - 1) begin
				if (s[i] != s[i+1]) begin
					first_edge = i[5:0];
				end
			end
		end
	endfunction

	// Proportion of ones outside a quarter to three quarters
	function apt_bad;
		input [23:0] ones;
		input [23:0] total;
		begin
			apt_bad = (total != 24'h00_0000) &&
				(({2'b00, ones} << 2) < {2'b00, total} ||
				({2'b00, ones} << 2) > ({2'b00, total} << 1) + {2'b00, total});
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	reg [1:0] xor_sync; // Second flop feeds logic
	reg [1:0] raw_sync;
	reg [1:0] osc_sync;
	reg [`CHAIN_LEN-1:0] taps_meta; // First stage, read only by taps_sync
	reg [`CHAIN_LEN-1:0] taps_sync;
	reg xor_d; // Previous synced XOR level
	reg osc_d;

	always @(posedge core_clk) begin
		xor_sync <= {xor_sync[0], xor_out};
		raw_sync <= {raw_sync[0], pll_raw};
		osc_sync <= {osc_sync[0], ring_osc_out};
		taps_meta <= chain_taps;
		taps_sync <= taps_meta;
		xor_d <= xor_sync[1];
		osc_d <= osc_sync[1];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pattern period timing and PLL tests
	wire [15:0] kd_last = (period_ratio == 16'h0000) ? 16'h0000 : period_ratio - 16'h0001;
	wire xor_edge = xor_sync[1] & ~xor_d; // One random sample
	reg [15:0] kd_cnt; // Cycles inside current pattern period
	reg [15:0] samp_cnt; // Samples inside current pattern period
	reg [15:0] prev_p1;
	reg [7:0] tf_cnt; // Pattern periods in total failure window
	reg [11:0] p2_cnt;
	reg [47:0] p2_acc; // Sum of squared period-to-period differences
	reg [11:0] ct_cnt; // Continuous test window
	reg started; // First total failure window done
	reg [`NUM_ERR-1:0] err;
	wire tq_end = (kd_cnt >= kd_last);
	wire [15:0] p1_now = samp_cnt + {15'h0000, xor_edge};
	wire [16:0] diff = {1'b0, p1_now} - {1'b0, prev_p1};
	wire [16:0] mag = diff[16] ? (17'h0_0000 - diff) : diff;
	wire [33:0] sq = mag * mag;
	wire [47:0] p2_sum = p2_acc + {14'h0000, sq};
	wire [34:0] p2_full = p2_sum[47:`P2_SHIFT];
	wire [15:0] p2_now = (p2_full > 35'h0_0000_ffff) ? 16'hffff : p2_full[15:0];
	wire halt = alarm; // Generation stops on alarm

	// Pattern period counters and parameter computation
	always @(posedge core_clk) begin
		if (!rst_n) begin
			kd_cnt <= 16'h0000;
			samp_cnt <= 16'h0000;
			prev_p1 <= 16'h0000;
			tf_cnt <= 8'h00;
			p2_cnt <= 12'h000;
			p2_acc <= 48'h0000_0000_0000;
			ct_cnt <= 12'h000;
			started <= 1'b0;
			sample_count_param <= 16'h0000;
			jitter_variance_param <= 16'h0000;
		end else if (tq_end) begin
			kd_cnt <= 16'h0000;
			samp_cnt <= 16'h0000;
			prev_p1 <= p1_now;
			sample_count_param <= p1_now; // RL5
			tf_cnt <= (tf_cnt == `TF_LAST) ? 8'h00 : tf_cnt + 8'h01; // RL3
			if (tf_cnt == `TF_LAST) begin
				started <= 1'b1; // RL22
			end
			ct_cnt <= ct_cnt + 12'h001; // RL18
			if (p2_cnt == `P2_LAST) begin
				p2_cnt <= 12'h000; // RL6
				p2_acc <= 48'h0000_0000_0000;
				jitter_variance_param <= p2_now;
			end else begin
				p2_cnt <= p2_cnt + 12'h001;
				p2_acc <= p2_sum;
			end
		end else begin
			kd_cnt <= kd_cnt + 16'h0001;
			samp_cnt <= p1_now; // RL3
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Delay-chain sampling, encoder and parity filter
	reg [15:0] div_cnt; // Sampling clock divider
	reg [`CHAIN_LEN-1:0] chain_reg; // 40-bit sample register
	reg [5:0] prev_pos;
	reg dc_raw; // Latest raw bit
	reg dc_raw_valid;
	reg par_phase; // Set while a pair waits for its second bit
	reg par_first;
	reg dc_par;
	reg dc_par_valid;
	wire samp_tick = (div_cnt == SAMPLE_DIV - 1) && !halt; // RL9
	wire [5:0] pos = first_edge(chain_reg);

	// Capture chain on divided tick, then encode position difference
	always @(posedge core_clk) begin
		if (!rst_n) begin
			div_cnt <= 16'h0000;
			chain_reg <= {`CHAIN_LEN{1'b0}};
			prev_pos <= 6'h00;
			dc_raw <= 1'b0;
			dc_raw_valid <= 1'b0;
			par_phase <= 1'b0;
			par_first <= 1'b0;
			dc_par <= 1'b0;
			dc_par_valid <= 1'b0;
		end else begin
			div_cnt <= (div_cnt == SAMPLE_DIV - 1) ? 16'h0000 : div_cnt + 16'h0001; // RL9
			dc_raw_valid <= samp_tick;
			dc_par_valid <= 1'b0;
			if (samp_tick) begin
				chain_reg <= taps_sync; // RL8
				prev_pos <= pos;
				dc_raw <= pos[0] ^ prev_pos[0]; // RL10
			end
			if (dc_raw_valid) begin
				par_phase <= ~par_phase;
				par_first <= dc_raw;
				if (par_phase) begin
					dc_par <= par_first ^ dc_raw; // RL11
					dc_par_valid <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Delay-chain failure and 512-bit block tests
	reg win_ph; // Two-cycle edge window phase
	reg toggled;
	reg [8:0] blk_cnt;
	reg [1:0] hist; // Two previous raw bits
	reg [8:0] tpl_cnt;
	reg [8:0] trn_cnt;
	reg [8:0] tpl_last;
	wire [8:0] tpl_next = tpl_cnt + {8'h00, (hist == 2'b11) & dc_raw};
	wire [8:0] trn_next = trn_cnt + {8'h00, hist[0] ^ dc_raw};

	// Pattern and transition counters per block
	always @(posedge core_clk) begin
		if (!rst_n) begin
			win_ph <= 1'b0;
			toggled <= 1'b0;
			blk_cnt <= 9'h000;
			hist <= 2'b00;
			tpl_cnt <= 9'h000;
			trn_cnt <= 9'h000;
			tpl_last <= 9'h000;
		end else begin
			win_ph <= ~win_ph;
			toggled <= win_ph ? 1'b0 : (osc_sync[1] ^ osc_d); // RL13
			if (dc_raw_valid) begin
				hist <= {hist[0], dc_raw};
				blk_cnt <= blk_cnt + 9'h001;
				if (blk_cnt == `BLOCK_LAST) begin
					tpl_cnt <= 9'h000;
					trn_cnt <= 9'h000;
					tpl_last <= tpl_next;
				end else begin
					tpl_cnt <= tpl_next; // RL15
					trn_cnt <= trn_next; // RL16
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Continuous tests on the streams entering post-processing
	reg [15:0] run_pll;
	reg [15:0] run_dc;
	reg last_pll;
	reg last_dc;
	reg [23:0] ones_pll;
	reg [23:0] bits_pll;
	reg [23:0] ones_dc;
	reg [23:0] bits_dc;
	wire ct_end = tq_end && (ct_cnt == `CT_LAST);

	// Run lengths and window proportions, on the pattern-period raw bit and parity output
	always @(posedge core_clk) begin
		if (!rst_n) begin
			run_pll <= 16'h0000;
			run_dc <= 16'h0000;
			last_pll <= 1'b0;
			last_dc <= 1'b0;
			ones_pll <= 24'h00_0000;
			bits_pll <= 24'h00_0000;
			ones_dc <= 24'h00_0000;
			bits_dc <= 24'h00_0000;
		end else begin
			if (tq_end) begin
				last_pll <= raw_sync[1];
				run_pll <= (raw_sync[1] == last_pll) ? run_pll + 16'h0001 : 16'h0000; // RL17
			end
			if (dc_par_valid) begin
				last_dc <= dc_par;
				run_dc <= (dc_par == last_dc) ? run_dc + 16'h0001 : 16'h0000; // RL17
			end
			if (ct_end) begin
				ones_pll <= 24'h00_0000; // RL18
				bits_pll <= 24'h00_0000;
				ones_dc <= 24'h00_0000;
				bits_dc <= 24'h00_0000;
			end else begin
				ones_pll <= ones_pll + {23'h00_0000, tq_end & raw_sync[1]};
				bits_pll <= bits_pll + {23'h00_0000, tq_end};
				ones_dc <= ones_dc + {23'h00_0000, dc_par_valid & dc_par};
				bits_dc <= bits_dc + {23'h00_0000, dc_par_valid};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky errors, alarm and state word
	reg [`NUM_ERR-1:0] next_err;

	// New failures are OR-ed in; only reset clears them
	always @* begin
		next_err = err; // RL23
		if (tq_end && p1_now == 16'h0000) next_err[`ERR_TF] = 1'b1; // RL4
		if (tq_end && !(p1_now > `P1_MIN && p1_now < {2'b00, period_ratio[15:2]}))
			next_err[`ERR_P1] = 1'b1; // RL7
		if (tq_end && p2_cnt == `P2_LAST && !(p2_now > `P2_MIN && p2_now < `P2_MAX))
			next_err[`ERR_P2] = 1'b1; // RL7
		if (win_ph && !toggled && !(osc_sync[1] ^ osc_d)) next_err[`ERR_STUCK] = 1'b1; // RL13
		if (dc_raw_valid && (chain_reg == {`CHAIN_LEN{1'b0}} ||
			chain_reg == {`CHAIN_LEN{1'b1}})) next_err[`ERR_NOEDGE] = 1'b1; // RL14
		if (dc_raw_valid && blk_cnt == `BLOCK_LAST && !(tpl_next > `TPL_MIN && tpl_next < `TPL_MAX))
			next_err[`ERR_TPL] = 1'b1; // RL15
		if (dc_raw_valid && blk_cnt == `BLOCK_LAST && !(trn_next > `TRN_MIN && trn_next < `TRN_MAX))
			next_err[`ERR_TRN] = 1'b1; // RL16
		if (run_pll >= RCT_CUTOFF) next_err[`ERR_RCT_PLL] = 1'b1; // RL17
		if (run_dc >= RCT_CUTOFF) next_err[`ERR_RCT_DC] = 1'b1;
		if (ct_end && apt_bad(ones_pll, bits_pll)) next_err[`ERR_APT_PLL] = 1'b1;
		if (ct_end && apt_bad(ones_dc, bits_dc)) next_err[`ERR_APT_DC] = 1'b1;
	end

	// Error register, alarm, interrupt pulse and status word
	always @(posedge core_clk) begin
		if (!rst_n) begin
			err <= {`NUM_ERR{1'b0}};
			alarm <= 1'b0;
			irq_req <= 1'b0;
			total_failure_alarm <= 1'b0;
			ready <= 1'b0;
			state_word <= 64'h0000_0000_0000_0000;
		end else begin
			err <= next_err; // RL23
			alarm <= |next_err; // RL20
			irq_req <= (|next_err) & ~alarm; // RL20
			total_failure_alarm <= next_err[`ERR_TF]; // RL4
			ready <= started & ~(|next_err); // RL22
			state_word <= 64'h0000_0000_0000_0000;
			state_word[`NUM_ERR-1:0] <= next_err; // RL19
			state_word[`SW_READY] <= started & ~(|next_err);
			state_word[`SW_P1_LO+15:`SW_P1_LO] <= sample_count_param;
			state_word[`SW_P2_LO+15:`SW_P2_LO] <= jitter_variance_param;
			state_word[`SW_TPL_LO+8:`SW_TPL_LO] <= tpl_last;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output routing by mode
	wire flow = ready & ~alarm; // RL21

	// User mode feeds post-processor; evaluation mode exposes core signals
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pll_pp_bit <= 1'b0;
			pll_pp_valid <= 1'b0;
			dc_pp_bit <= 1'b0;
			dc_pp_valid <= 1'b0;
			eval_pll_bit <= 1'b0;
			eval_pll_valid <= 1'b0;
			eval_dc_raw <= 1'b0;
			eval_dc_parity <= 1'b0;
			eval_dc_valid <= 1'b0;
		end else begin
			pll_pp_bit <= raw_sync[1]; // RL2
			pll_pp_valid <= ~eval_mode & flow & tq_end & ~halt; // RL21
			dc_pp_bit <= dc_par;
			dc_pp_valid <= ~eval_mode & flow & dc_par_valid; // RL21
			eval_pll_bit <= output_select ? xor_sync[1] : raw_sync[1]; // RL1
			eval_pll_valid <= eval_mode & ~halt & (output_select | tq_end); // RL1
			eval_dc_raw <= dc_raw; // RL12
			eval_dc_parity <= dc_par;
			eval_dc_valid <= eval_mode & dc_raw_valid; // RL12
		end
	end

endmodule // trng_health_monitor

// *** verilog/trng_health_map.vh ***
// Constants for the generator health monitor: thresholds, windows, state word layout.
// Assumes inclusion by bare name from the monitor module only.
`ifndef TRNG_HEALTH_MAP_VH
`define TRNG_HEALTH_MAP_VH
// Pattern-period based test windows
`define TF_LAST 8'hfe
`define P2_LAST 12'hfef
`define CT_LAST 12'hfff
// Online test thresholds (strict bounds)
`define P1_MIN 16'h0004
`define P2_MIN 16'h00e4
`define P2_MAX 16'h0500
`define P2_SHIFT 13
// Delay chain and 512-bit block tests
`define CHAIN_LEN 40
`define BLOCK_LAST 9'h1ff
`define TPL_MIN 9'h023
`define TPL_MAX 9'h05d
`define TRN_MIN 9'h0b9
`define TRN_MAX 9'h146
// Error bit positions in the state word
`define ERR_TF 0
`define ERR_P1 1
`define ERR_P2 2
`define ERR_STUCK 3
`define ERR_NOEDGE 4
`define ERR_TPL 5
`define ERR_TRN 6
`define ERR_RCT_PLL 7
`define ERR_RCT_DC 8
`define ERR_APT_PLL 9
`define ERR_APT_DC 10
`define NUM_ERR 11
// Other state word fields
`define SW_READY 11
`define SW_P1_LO 16
`define SW_P2_LO 32
`define SW_TPL_LO 48
`endif

// *** sim/trng_health_monitor_monitor.sv ***
// Checker for the health monitor: alarm path, stream gating, state word.
// Assumes it is bound to trng_health_monitor and sees only its ports.
`timescale 1ns/1ps
module trng_health_checker (
	// Clock, reset and control
	input wire core_clk,
	input wire rst_n,
	input wire eval_mode,
	input wire output_select,
	// Stream strobes
	input wire pll_pp_valid,
	input wire dc_pp_valid,
	input wire eval_pll_valid,
	input wire eval_dc_valid,
	// Status
	input wire [63:0] state_word,
	input wire total_failure_alarm,
	input wire alarm,
	input wire irq_req,
	input wire ready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// Mode held three cycles, so the registered outputs have settled
	sequence user_held; !eval_mode [*3]; endsequence
	sequence eval_held; eval_mode [*3]; endsequence
	sequence xor_held; (eval_mode && output_select && ready && !alarm) [*3]; endsequence
	chk_xor_valid: assert property (xor_held |-> eval_pll_valid)
		else $error("xor view not valid");
	chk_user_quiet: assert property (user_held |-> !eval_pll_valid && !eval_dc_valid)
		else $error("eval strobe in user mode");
	chk_eval_quiet: assert property (eval_held |-> !pll_pp_valid && !dc_pp_valid)
		else $error("post stream in eval mode");
	chk_tf_flag: assert property (total_failure_alarm |-> alarm && state_word[0])
		else $error("total failure not flagged");
	chk_word_errs: assert property (alarm == (|state_word[10:0]))
		else $error("alarm differs from error bits");
	chk_ready_bit: assert property (state_word[11] == ready)
		else $error("ready bit differs");
	chk_irq_rise: assert property ($rose(alarm) |-> irq_req)
		else $error("irq missing on alarm");
	chk_irq_pulse: assert property (irq_req |-> alarm && !$past(alarm))
		else $error("irq without alarm rise");
	chk_alarm_hold: assert property (alarm |=> alarm)
		else $error("alarm cleared without reset");
	chk_alarm_gate: assert property (alarm |=> !pll_pp_valid && !dc_pp_valid && !ready)
		else $error("data flows during alarm");
	chk_reset_clear: assert property ($rose(rst_n) |-> !alarm && !ready && !irq_req)
		else $error("status not clear after reset");
endmodule // trng_health_checker

bind trng_health_monitor trng_health_checker chk_u (.core_clk, .rst_n, .eval_mode,
	.output_select, .pll_pp_valid, .dc_pp_valid, .eval_pll_valid, .eval_dc_valid,
	.state_word, .total_failure_alarm, .alarm, .irq_req, .ready);

// *** sim/trng_entropy_model.sv ***
// Model of both entropy cores driving the monitor's pins.
// Assumes a 16-cycle sampling tick; raw bits follow a balanced 8-bit pattern.
`timescale 1ns/1ps
module trng_entropy_model (
	// Clock and scenario
	input wire core_clk,
	input wire [1:0] fault,
	input wire [7:0] n_edges,
	input wire [15:0] period,
	// Core pins
	output reg xor_out,
	output reg pll_raw,
	output reg ring_osc_out,
	output reg [39:0] chain_taps
);
	////////////////////////////////////////
	reg [15:0] phase = 16'h0000; // Place in pattern period
	reg [3:0] div = 4'h0; // Tap update cadence
	reg [2:0] idx = 3'h0; // Raw pattern index
	reg edge_lsb = 1'b0; // Parity of edge position
	reg [31:0] rnd;
	// Pattern keeps template and transition counts centred, so no false alarms
	wire [7:0] pat = 8'h17;
	initial {xor_out, pll_raw, ring_osc_out, chain_taps} = 43'h0;
	// Periodic xor pattern gives exactly n_edges rises in any period window
	always @(negedge core_clk) begin
		rnd = $urandom;
		phase <= (phase + 16'h0001 >= period) ? 16'h0000 : phase + 16'h0001;
		xor_out <= (phase < {7'h00, n_edges, 1'b0}) && phase[0];
		pll_raw <= rnd[0];
		ring_osc_out <= (fault == 2'h1) ? 1'b0 : ~ring_osc_out;
		div <= div + 4'h1;
		if (div == 4'hf) begin
			edge_lsb = edge_lsb ^ pat[idx];
			idx <= idx + 3'h1;
			// Random edge position with chosen parity; no edge under fault code 2
			chain_taps <= (fault == 2'h2) ? 40'h0 :
				(40'h1 << (2 * (rnd[15:8] % 19) + edge_lsb + 1)) - 40'h1;
		end
	end
endmodule // trng_entropy_model

// *** sim/trng_health_monitor_tb_top.sv ***
// Self-checking bench for the health monitor with a behavioural entropy source.
// Assumes period_ratio 64 and the default 16-cycle sampling divider.
`timescale 1ns/1ps
module trng_health_monitor_tb_top;
	// Stimulus
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg eval_mode = 1'b0;
	reg output_select = 1'b0;
	reg [15:0] period_ratio = 16'h0040;
	reg [1:0] fault = 2'h0;
	reg [7:0] n_edges = 8'h08;
	reg [13:0] row;
	wire xor_out, pll_raw, ring_osc_out;
	wire [39:0] chain_taps;
	// Observed
	wire pll_pp_bit, pll_pp_valid, dc_pp_bit, dc_pp_valid;
	wire eval_pll_bit, eval_pll_valid, eval_dc_raw, eval_dc_parity, eval_dc_valid;
	wire [63:0] state_word;
	wire [15:0] sample_count_param, jitter_variance_param;
	wire total_failure_alarm, alarm, irq_req, ready;
	wire [1:0] flags = {alarm, ready};
	// Strobe and bit pairs picked by pulses(): 4 is the parity view under the raw strobe
	wire [4:0] vld = {eval_dc_valid, eval_dc_valid, eval_pll_valid, dc_pp_valid, pll_pp_valid};
	wire [4:0] bits = {eval_dc_parity, eval_dc_raw, eval_pll_bit, dc_pp_bit, pll_pp_bit};
	integer err_count = 0;
	integer samples_checked = 0;
	integer np, ones, i;
	always #20 core_clk = ~core_clk;
	trng_entropy_model src_u (.core_clk, .fault, .n_edges, .period(period_ratio),
		.xor_out, .pll_raw, .ring_osc_out, .chain_taps);
	trng_health_monitor dut_u (.core_clk, .rst_n, .eval_mode, .output_select,
		.period_ratio, .xor_out, .pll_raw, .ring_osc_out, .chain_taps, .pll_pp_bit,
		.pll_pp_valid, .dc_pp_bit, .dc_pp_valid, .eval_pll_bit, .eval_pll_valid,
		.eval_dc_raw, .eval_dc_parity, .eval_dc_valid, .state_word, .sample_count_param,
		.jitter_variance_param, .total_failure_alarm, .alarm, .irq_req, .ready);
	////////////////////////////////////////
	// Pulses expected in a window of steady cadence
	function integer exp_count(input integer cyc, input integer every);
		exp_count = cyc / every;
	endfunction
	// Fault table: fault code, edges per period, error bit expected
	function [13:0] fault_row(input integer k);
		case (k)
			0: fault_row = {2'h0, 8'h00, 4'h0};
			1: fault_row = {2'h0, 8'h04, 4'h1};
			2: fault_row = {2'h0, 8'h10, 4'h1};
			3: fault_row = {2'h1, 8'h08, 4'h3};
			default: fault_row = {2'h2, 8'h08, 4'h4};
		endcase
	endfunction
	task check(input [63:0] seen, input [63:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
			end
		end
	endtask
	task close_out;
		begin
			if (err_count == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// Reset with a new scenario applied
	task start(input [1:0] f, input [7:0] n, input m);
		begin
			@(negedge core_clk);
			{fault, n_edges, eval_mode, rst_n} = {f, n, m, 1'b0};
			repeat (5) @(negedge core_clk);
			rst_n = 1'b1;
		end
	endtask
	// Bounded wait on ready (0) or alarm (1)
	task wait_on(input integer sel, input integer lim);
		integer n;
		begin
			n = 0;
			while (flags[sel] !== 1'b1 && n < lim) begin
				@(negedge core_clk);
				n = n + 1;
			end
			if (flags[sel] !== 1'b1) begin
				err_count = err_count + 1;
				$display("Error at %0t: wait timed out", $time);
				close_out;
			end
		end
	endtask
	// Count strobes and their one bits over a window
	task pulses(input integer sel, input integer cyc);
		begin
			np = 0;
			ones = 0;
			repeat (cyc) begin
				@(posedge core_clk);
				#1;
				np = np + vld[sel];
				ones = ones + (vld[sel] & bits[sel]);
			end
		end
	endtask
	////////////////////////////////////////
	initial begin
		i = $urandom(5547);
		i = $urandom % 10;
		start(2'h0, 8'h05 + i[7:0], 1'b0);
		wait_on(0, 17000);
		check(sample_count_param, n_edges);
		check(state_word[31:16], n_edges);
		// Startup spans 255 periods, so no variance window has closed yet
		check(jitter_variance_param, 16'h0000);
		pulses(0, 640);
		check(np, exp_count(640, 64));
		pulses(1, 640);
		check(np, exp_count(640, 32));
		check(ones, exp_count(640, 64));
		// Evaluation views, raw PLL bit selected by default
		@(negedge core_clk);
		eval_mode = 1'b1;
		repeat (4) @(negedge core_clk);
		pulses(2, 640);
		check(np, exp_count(640, 64));
		pulses(3, 640);
		check(np, exp_count(640, 16));
		check(ones, exp_count(640, 32));
		// Parity view repeats every 8 raw strobes with half of them set
		pulses(4, 640);
		check(np, exp_count(640, 16));
		check(ones, exp_count(640, 32));
		@(negedge core_clk);
		output_select = 1'b1;
		// XOR view: strobe every cycle, one high cycle per edge in a period
		pulses(2, 64);
		check(np, 64);
		check(ones, n_edges);
		// Each fault must latch its error bit until reset
		for (i = 0; i < 5; i = i + 1) begin
			row = fault_row(i);
			start(row[13:12], row[11:4], 1'b0);
			wait_on(1, 1000);
			{fault, n_edges} = {2'h0, 8'h08};
			repeat (200) @(negedge core_clk);
			check(state_word[row[3:0]], 1'b1);
			check(total_failure_alarm, row[3:0] == 4'h0);
			check(ready, 1'b0);
		end
		start(2'h0, 8'h08, 1'b0);
		wait_on(0, 17000);
		check(state_word[10:0], 11'h000);
		close_out;
	end
endmodule // trng_health_monitor_tb_top
